// ### hbp_consts.svh
// hbp_consts.svh: strap encodings, widths and timing counts for the host bus pin front end.
// assumes it is included by its bare name from the package and the design modules.
`ifndef HBP_CONSTS_SVH
`define HBP_CONSTS_SVH

// ****************************************
// strap encodings
// ****************************************
`define HBP_STYLE_GENERIC 2'h0
`define HBP_STYLE_M68K 2'h1
`define HBP_STYLE_ECLK 2'h2
`define HBP_ADDR_INDIRECT 1'h0
`define HBP_ADDR_DIRECT 1'h1

// ****************************************
// widths and timing
// ****************************************
`define HBP_DATA_W 8
`define HBP_ADDR_W 16
`define HBP_CLK_NS 20
`define HBP_SHIFT_BASE_DIV 4'h2
`define HBP_WAIT_CYCLES 3'h2
`define HBP_RESET_DATA 8'h00

`endif

// ### hbp_pkg.sv
// hbp_pkg.sv: types shared by the host bus pin front end.
// assumes hbp_consts.svh sits in the same folder.
`include "hbp_consts.svh"
package hbp_pkg;
    typedef enum logic [1:0] {HBP_GENERIC, HBP_M68K, HBP_ECLK} hbp_style_e;
    typedef enum logic [1:0] {HBP_K_NONE, HBP_K_WRITE, HBP_K_READ} hbp_kind_e;
    typedef logic [7:0] hbp_byte_t;
endpackage

// ### hbp_strap_latch.sv
// hbp_strap_latch.sv: captures the configuration straps once after reset release.
// assumes straps are tied statically on the board.
`timescale 1ns/1ps
`default_nettype none
module hbp_strap_latch (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [4:0] straps,
    output logic [4:0] latched,
    output logic valid
);
    // ****************************************
    // capture after release, never under reset
    // ****************************************
    logic [4:0] latched_q;
    logic valid_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latched_q <= 5'h00;
            valid_q <= 1'b0;
        end else if (!valid_q) begin
            latched_q <= straps;
            valid_q <= 1'b1;
        end
    end
    assign latched = latched_q;
    assign valid = valid_q;
endmodule
`default_nettype wire

// ### hbp_shift_clk.sv
// hbp_shift_clk.sv: divides the core clock into the pixel shift clock.
// assumes the period strap is already stable.
`timescale 1ns/1ps
`default_nettype none
`include "hbp_consts.svh"
module hbp_shift_clk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    input wire logic [1:0] period_sel,
    output logic shift_clk
);
    // ****************************************
    // half period doubles per strap step
    // ****************************************
    logic [5:0] cnt_q;
    logic shift_q;
    wire [5:0] half_len = 6'({2'h0, `HBP_SHIFT_BASE_DIV} << period_sel);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 6'h00;
            shift_q <= 1'b0;
        end else if (!en) begin
            cnt_q <= 6'h00;
            shift_q <= 1'b0;
        end else if (cnt_q >= half_len - 6'h01) begin
            cnt_q <= 6'h00;
            shift_q <= ~shift_q;
        end else begin
            cnt_q <= cnt_q + 6'h01;
        end
    end
    assign shift_clk = shift_q;
endmodule
`default_nettype wire

// ### hbp_host_port.sv
// hbp_host_port.sv: top of the parallel host port front end.
// assumes host pins are synchronous to MCLK; the core answers reads from RD_DATA.
`timescale 1ns/1ps
`default_nettype none
`include "hbp_consts.svh"
module hbp_host_port (
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic [1:0] SHIFT_PERIOD_STRAP,
    input wire logic [1:0] BUS_STYLE_STRAP,
    input wire logic ADDRESSING_MODE_STRAP,
    input wire logic CHIP_SELECT_N,
    input wire logic READ_STROBE,
    input wire logic WRITE_CTRL,
    input wire logic [14:0] UPPER_ADDRESS,
    input wire logic LOW_ADDRESS_BIT,
    input wire logic [7:0] DATA_IN,
    output logic [7:0] DATA_OUT,
    output logic DATA_OE,
    output logic WAIT_OUT,
    output logic WAIT_OE,
    input wire hbp_pkg::hbp_byte_t RD_DATA,
    output logic WR_PULSE,
    output logic RD_PULSE,
    output logic [15:0] HOST_ADDR,
    output logic CMD_BYTE,
    output logic [7:0] WR_DATA,
    output logic PIXEL_SHIFT_CLOCK
);
    import hbp_pkg::*;

    // ****************************************
    // strap capture and decode
    // ****************************************
    logic [4:0] straps_l;
    logic cfg_valid;
    hbp_strap_latch u_straps (
        .clk(MCLK),
        .rst_n(RESETN),
        .straps({ADDRESSING_MODE_STRAP, BUS_STYLE_STRAP, SHIFT_PERIOD_STRAP}),
        .latched(straps_l),
        .valid(cfg_valid)
    );
    wire [1:0] shift_period_strap = straps_l[1:0];
    wire direct_mode = (straps_l[4] == `HBP_ADDR_DIRECT);
    hbp_style_e style;
    assign style = (straps_l[3:2] == `HBP_STYLE_M68K) ? HBP_M68K :
                   (straps_l[3:2] == `HBP_STYLE_ECLK) ? HBP_ECLK : HBP_GENERIC;

    // ****************************************
    // access detection per bus style
    // ****************************************
    // the shared strobe means different things per style; decode to one active level
    wire selected = cfg_valid && !CHIP_SELECT_N;
    wire lower_byte_strobe_n = READ_STROBE;
    wire gen_read = !READ_STROBE;
    wire gen_write = !WRITE_CTRL;
    wire eclk_on = READ_STROBE;
    wire m68k_on = !lower_byte_strobe_n;
    wire strobe_on = (style == HBP_ECLK) ? eclk_on :
                     (style == HBP_M68K) ? m68k_on : (gen_read || gen_write);
    wire is_read = (style == HBP_GENERIC) ? gen_read : WRITE_CTRL;
    wire active = selected && strobe_on;
    wire read_active = active && is_read;

    // style tests recur in several decodes; one helper keeps them consistent
    function automatic logic is_generic(input hbp_style_e s);
        return s == HBP_GENERIC;
    endfunction

    // one short register per signal keeps the reset values easy to audit
    logic active_q;
    logic read_q;
    logic gen_wr_q;
    wire gen_style = is_generic(style);
    wire active_d = active;
    wire read_d = read_active;
    wire gen_wr_d = selected && gen_style && gen_write;

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            active_q <= 1'b0;
        end else begin
            active_q <= active_d;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            read_q <= 1'b0;
        end else begin
            read_q <= read_d;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            gen_wr_q <= 1'b0;
        end else begin
            gen_wr_q <= gen_wr_d;
        end
    end

    // generic writes complete on the write strobe's rising edge
    wire gen_wr_rise = gen_wr_q && WRITE_CTRL;
    wire access_start = active && !active_q;
    wire other_wr_start = access_start && !is_read && !gen_style;
    wire wr_event = gen_style ? gen_wr_rise : other_wr_start;
    wire rd_event = read_active && !read_q;

    // ****************************************
    // address and byte type
    // ****************************************
    // indirect mode ignores the upper lines, which the board grounds anyway
    wire [14:0] upper_used = direct_mode ? UPPER_ADDRESS : 15'h0000;
    wire [15:0] addr_now = {upper_used, LOW_ADDRESS_BIT};
    wire cmd_now = !direct_mode && LOW_ADDRESS_BIT;

    // ****************************************
    // registered outputs
    // ****************************************
    logic [7:0] data_out_q;
    logic data_oe_q;
    logic wr_pulse_q;
    logic rd_pulse_q;
    logic [15:0] host_addr_q;
    logic cmd_byte_q;
    logic [7:0] wr_data_q;
    logic [7:0] wr_hold_q;

    // the hold register follows the bus while the write strobe is low, so its
    // last sample before the rising edge is the byte that the host meant
    wire hold_load = gen_wr_q && !WRITE_CTRL;
    wire addr_load = wr_event || rd_event;
    // read data is resampled every cycle so a read shows the core's latest byte
    wire [7:0] data_out_d = RD_DATA;
    wire data_oe_d = read_active;
    wire wr_pulse_d = wr_event;
    wire rd_pulse_d = rd_event;
    wire [15:0] host_addr_d = addr_load ? addr_now : host_addr_q;
    wire cmd_byte_d = addr_load ? cmd_now : cmd_byte_q;
    wire [7:0] wr_hold_d = hold_load ? DATA_IN : wr_hold_q;
    wire [7:0] wr_data_sel = gen_style ? wr_hold_q : DATA_IN;
    wire [7:0] wr_data_d = wr_event ? wr_data_sel : wr_data_q;

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            data_out_q <= `HBP_RESET_DATA;
        end else begin
            data_out_q <= data_out_d;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            data_oe_q <= 1'b0;
        end else begin
            data_oe_q <= data_oe_d;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            wr_pulse_q <= 1'b0;
        end else begin
            wr_pulse_q <= wr_pulse_d;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            rd_pulse_q <= 1'b0;
        end else begin
            rd_pulse_q <= rd_pulse_d;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            host_addr_q <= 16'h0000;
        end else begin
            host_addr_q <= host_addr_d;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            cmd_byte_q <= 1'b0;
        end else begin
            cmd_byte_q <= cmd_byte_d;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            wr_hold_q <= `HBP_RESET_DATA;
        end else begin
            wr_hold_q <= wr_hold_d;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            wr_data_q <= `HBP_RESET_DATA;
        end else begin
            wr_data_q <= wr_data_d;
        end
    end

    // ****************************************
    // wait handshake, generic direct only
    // ****************************************
    typedef enum logic [1:0] {W_IDLE, W_HOLD, W_DONE} hbp_wait_e;
    hbp_wait_e wst_q;
    hbp_wait_e wst_d;
    logic [2:0] wcnt_q;

    // wait is only ever driven in generic direct mode; elsewhere the pin stays released
    wire wait_used = direct_mode && gen_style;
    wire hold_done = wcnt_q == `HBP_WAIT_CYCLES;
    always_comb begin
        wst_d = wst_q;
        case (wst_q)
            W_IDLE: begin
                if (wait_used && access_start) begin
                    wst_d = W_HOLD;
                end
            end
            W_HOLD: begin
                if (hold_done) begin
                    wst_d = W_DONE;
                end
            end
            W_DONE: begin
                if (!active) begin
                    wst_d = W_IDLE;
                end
            end
            default: begin
                wst_d = W_IDLE;
            end
        endcase
    end

    // the counter restarts on every entry, so each access gets a full hold
    logic wait_out_q;
    logic wait_oe_q;
    wire [2:0] wcnt_d = (wst_d == W_HOLD) ? wcnt_q + 3'h1 : 3'h0;
    wire wait_out_d = wst_d != W_HOLD;
    wire wait_oe_d = wst_d != W_IDLE;

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            wst_q <= W_IDLE;
        end else begin
            wst_q <= wst_d;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            wcnt_q <= 3'h0;
        end else begin
            wcnt_q <= wcnt_d;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            wait_out_q <= 1'b1;
        end else begin
            wait_out_q <= wait_out_d;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            wait_oe_q <= 1'b0;
        end else begin
            wait_oe_q <= wait_oe_d;
        end
    end

    // ****************************************
    // pixel shift clock
    // ****************************************
    logic shift_clk;
    hbp_shift_clk u_shift (
        .clk(MCLK),
        .rst_n(RESETN),
        .en(cfg_valid),
        .period_sel(shift_period_strap),
        .shift_clk(shift_clk)
    );

    assign DATA_OUT = data_out_q;
    assign DATA_OE = data_oe_q;
    assign WAIT_OUT = wait_out_q;
    assign WAIT_OE = wait_oe_q;
    assign WR_PULSE = wr_pulse_q;
    assign RD_PULSE = rd_pulse_q;
    assign HOST_ADDR = host_addr_q;
    assign CMD_BYTE = cmd_byte_q;
    assign WR_DATA = wr_data_q;
    assign PIXEL_SHIFT_CLOCK = shift_clk;
endmodule
`default_nettype wire

// ### hbp_host_port_props.sv
// hbp_host_port_props.sv: concurrent checks on the host port pins.
// assumes straps only move while RESETN is low.
`timescale 1ns/1ps
`default_nettype none
module hbp_host_port_chk (
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic [1:0] BUS_STYLE_STRAP,
    input wire logic ADDRESSING_MODE_STRAP,
    input wire logic CHIP_SELECT_N,
    input wire logic READ_STROBE,
    input wire logic WRITE_CTRL,
    input wire logic DATA_OE,
    input wire logic WAIT_OUT,
    input wire logic WAIT_OE,
    input wire logic WR_PULSE,
    input wire logic RD_PULSE,
    input wire logic [15:0] HOST_ADDR
);
    // ********
    // checks
    // ********
    // code 11 counts as generic, so generic is "neither of the other two"
    wire gen = BUS_STYLE_STRAP != 2'h1 && BUS_STYLE_STRAP != 2'h2;
    wire rd_gen = !CHIP_SELECT_N && !READ_STROBE;
    wire rd_ec = !CHIP_SELECT_N && READ_STROBE && WRITE_CTRL;
    wire rd_68 = !CHIP_SELECT_N && !READ_STROBE && WRITE_CTRL;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    a_oe_generic_read: assert property (gen && DATA_OE |-> $past(rd_gen) || $past(rd_gen, 2))
        else $error("generic data driven outside read");
    a_oe_eclk_read: assert property (BUS_STYLE_STRAP == 2'h2 && DATA_OE |-> $past(rd_ec) || $past(rd_ec, 2))
        else $error("eclk data driven outside read");
    a_oe_m68k_read: assert property (BUS_STYLE_STRAP == 2'h1 && DATA_OE |-> $past(rd_68) || $past(rd_68, 2))
        else $error("m68k data driven outside read");
    a_wait_mode_only: assert property (WAIT_OE |-> gen && ADDRESSING_MODE_STRAP)
        else $error("wait enabled outside generic direct");
    a_wait_hold_seq: assert property ($rose(WAIT_OE) |-> !WAIT_OUT [*2] ##1 WAIT_OUT)
        else $error("wait hold sequence wrong");
    a_indirect_upper_zero: assert property (WR_PULSE && !ADDRESSING_MODE_STRAP |-> HOST_ADDR[15:1] == 15'h0)
        else $error("indirect upper address not zero");
    a_read_cs_dir: assert property (RD_PULSE |-> $past(!CHIP_SELECT_N) && (gen || $past(WRITE_CTRL)))
        else $error("read started without select or direction");
    a_write_rise_edge: assert property (gen && WR_PULSE |-> $past(WRITE_CTRL) && !$past(WRITE_CTRL, 2))
        else $error("generic write not at strobe rise");
    a_reset_quiet: assert property (disable iff (1'b0) !RESETN |-> !DATA_OE && !WAIT_OE && !WR_PULSE && !RD_PULSE)
        else $error("output active during reset");
endmodule
bind hbp_host_port hbp_host_port_chk u_chk (.MCLK(MCLK), .RESETN(RESETN),
    .BUS_STYLE_STRAP(BUS_STYLE_STRAP), .ADDRESSING_MODE_STRAP(ADDRESSING_MODE_STRAP),
    .CHIP_SELECT_N(CHIP_SELECT_N), .READ_STROBE(READ_STROBE), .WRITE_CTRL(WRITE_CTRL),
    .DATA_OE(DATA_OE), .WAIT_OUT(WAIT_OUT), .WAIT_OE(WAIT_OE), .WR_PULSE(WR_PULSE),
    .RD_PULSE(RD_PULSE), .HOST_ADDR(HOST_ADDR));
`default_nettype wire

// ### hbp_host_model.sv
// hbp_host_model.sv: behavioural host processor on the parallel bus.
// assumes its pins change 1 ns after the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module hbp_host_model (
    input wire logic clk,
    output logic cs_n,
    output logic rs,
    output logic wc,
    output logic [14:0] ua,
    output logic low_bit,
    output logic [7:0] din,
    input wire logic [7:0] dout,
    input wire logic doe
);
    // ********
    // bus
    // ********
    logic h_oe;
    logic [7:0] h_d;
    logic [7:0] last;
    // undriven bus toggles each cycle so stale data never matches by luck
    assign din = doe ? dout : (h_oe ? h_d : ~last);
    always @(posedge clk) last <= din;
    initial begin
        cs_n = 1'b1;
        rs = 1'b1;
        wc = 1'b1;
        {ua, low_bit} = 16'h0;
        h_oe = 1'b0;
        h_d = 8'h00;
        last = 8'h00;
    end
    task automatic xfer(input logic [1:0] s, input logic w, input logic [15:0] a,
            input logic [7:0] d, input logic sel);
        logic gen;
        gen = s != 2'h1 && s != 2'h2;
        @(posedge clk);
        #1;
        cs_n = !sel;
        {ua, low_bit} = a;
        h_d = d;
        h_oe = w;
        wc = !w;
        rs = (s == 2'h2) || (gen && w);
        repeat (5) @(posedge clk);
        #1;
        rs = s != 2'h2;
        if (gen) wc = 1'b1;
        @(posedge clk);
        #1;
        wc = 1'b1;
        cs_n = 1'b1;
        h_oe = 1'b0;
    endtask
endmodule
`default_nettype wire

// ### tb_host_bus_pin_interface.sv
// tb_host_bus_pin_interface.sv: self-checking bench for the host port front end.
// assumes the host model drives the pins and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module tb_host_bus_pin_interface;
    import hbp_pkg::*;
    // ********
    // setup
    // ********
    logic mclk = 1'b0;
    logic rst_n = 1'b1;
    logic [1:0] sp = 2'h0;
    logic [1:0] bs = 2'h0;
    logic am = 1'b1;
    hbp_byte_t rdd = 8'h00;
    wire cs_n, rs, wc, lab, doe, wo, woe, wp, rp, cb, psc;
    wire gen_dir = bs != 2'h1 && bs != 2'h2 && am;
    wire [14:0] ua;
    wire [7:0] din, dout, wd;
    wire [15:0] ha;
    logic [24:0] wq[$];
    logic [7:0] rq[$];
    int mismatches = 0;
    int checks = 0;
    int cyc = 0;
    // {style, direct}: generic both modes, 68K-style both, E-clock indirect only
    logic [2:0] cfg [5] = '{3'h1, 3'h0, 3'h3, 3'h2, 3'h4};
    hbp_host_port DUT (.MCLK(mclk), .RESETN(rst_n), .SHIFT_PERIOD_STRAP(sp),
        .BUS_STYLE_STRAP(bs), .ADDRESSING_MODE_STRAP(am), .CHIP_SELECT_N(cs_n),
        .READ_STROBE(rs), .WRITE_CTRL(wc), .UPPER_ADDRESS(ua), .LOW_ADDRESS_BIT(lab),
        .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe), .WAIT_OUT(wo), .WAIT_OE(woe),
        .RD_DATA(rdd), .WR_PULSE(wp), .RD_PULSE(rp), .HOST_ADDR(ha), .CMD_BYTE(cb),
        .WR_DATA(wd), .PIXEL_SHIFT_CLOCK(psc));
    hbp_host_model host (.clk(mclk), .cs_n(cs_n), .rs(rs), .wc(wc), .ua(ua), .low_bit(lab),
        .din(din), .dout(dout), .doe(doe));
    always #10 mclk = ~mclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    // ********
    // watcher
    // ********
    always @(posedge mclk) begin
        if (rst_n === 1'b1 && wp !== 1'b0) chk({cb, ha, wd}, wq.size() ? wq.pop_front() : 32'h2000000);
        if (rst_n === 1'b1 && rp !== 1'b0) chk(dout, rq.size() ? rq.pop_front() : 32'h100);
        if (rst_n === 1'b1 && rp !== 1'b0) chk({doe, woe, wo}, {1'b1, gen_dir, !gen_dir});
        if (rst_n === 1'b1 && wp !== 1'b0) chk(woe, 1'b0);
    end
    // ********
    // scenarios
    // ********
    task automatic boot(input logic [2:0] c, input logic [1:0] p);
        @(posedge mclk);
        #1;
        rst_n = 1'b0;
        {bs, am} = c;
        sp = p;
        repeat (2) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        repeat (2) @(posedge mclk);
    endtask
    task automatic chk_shift(input int h);
        logic v;
        int n;
        int c;
        n = 0;
        c = 0;
        v = psc;
        repeat (80) begin
            @(posedge mclk);
            if (n == 1) c++;
            if (psc !== v) begin
                v = psc;
                n++;
                if (n == 2) chk(c, h);
            end
        end
        chk(n > 1, 1);
    endtask
    initial begin
        logic [15:0] a;
        logic [7:0] d;
        int i;
        i = $urandom(32'h420308F1);
        #1;
        rst_n = 1'b0;
        for (i = 0; i < 5; i++) begin
            boot(cfg[i], i[1:0]);
            chk_shift(2 << i[1:0]);
            repeat (2) begin
                a = $urandom();
                d = $urandom();
                if (!am) a[15:1] = 15'h0;
                wq.push_back({!am && a[0], a, d});
                host.xfer(bs, 1'b1, a, d, 1'b1);
                rdd = $urandom();
                rq.push_back(rdd);
                host.xfer(bs, 1'b0, a, 8'h00, 1'b1);
            end
            // strobes with chip select high must leave no trace
            host.xfer(bs, 1'b1, a, d, 1'b0);
            host.xfer(bs, 1'b0, a, d, 1'b0);
        end
        repeat (4) @(posedge mclk);
        chk(wq.size() + rq.size(), 0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
